// ===== logic/ufl_uart.v
// One UART channel: host register port, FIFOs, line format and line status.
// Assumes host strobes are one-cycle pulses synchronous to clk and rx is synchronous too.
`timescale 1ns/100ps
`default_nettype none
`include "ufl_regs.vh"

module ufl_uart #(
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Host register port
  input  wire [2:0] addr,
  input  wire       wr_stb,
  input  wire       rd_stb,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  // Enhanced function enable level
  input  wire       enhanced_function_enable,
  // Serial line
  input  wire       rx,
  output reg        tx,
  // Status toward DMA and flow logic
  output wire       dma_mode,
  output wire       fifo_enabled,
  output wire       tx_trigger_hit,
  output wire       rx_trigger_hit
);

  localparam RS_IDLE = 6'h01;
  localparam RS_STRT = 6'h02;
  localparam RS_DATA = 6'h04;
  localparam RS_PAR  = 6'h08;
  localparam RS_STOP = 6'h10;
  localparam RS_BRKW = 6'h20;

  localparam TS_IDLE = 5'h01;
  localparam TS_STRT = 5'h02;
  localparam TS_DATA = 5'h04;
  localparam TS_PAR  = 5'h08;
  localparam TS_STOP = 5'h10;

  // Parity bit to send or expect for a character under the current format.
  function par_bit;
    input [7:0] d;
    input [7:0] lc;
    begin
      if (lc[`UFL_LC_FORCE]) begin
        par_bit = ~lc[`UFL_LC_EVEN];
      end else if (lc[`UFL_LC_EVEN]) begin
        par_bit = ^d;
      end else begin
        par_bit = ~^d;
      end
    end
  endfunction

  // Keeps only the active data bits of a character.
  function [7:0] wmask;
    input [7:0] d;
    input [1:0] wl;
    begin
      wmask = d & (8'hff >> (3'h3 - {1'b0, wl}));
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        fen_reg;
  reg        dma_reg;
  reg [1:0]  txtrg_reg;
  reg [1:0]  rxtrg_reg;
  reg [7:0]  lc_reg;
  reg [7:0]  divlo_reg;
  reg [7:0]  divhi_reg;
  reg        ovr_reg;

  wire dlab     = lc_reg[`UFL_LC_DLAB];
  wire wr_data0 = wr_stb && (addr == `UFL_ADDR_DATA) && !dlab;
  wire wr_fc    = wr_stb && (addr == `UFL_ADDR_FIFOCTL);
  wire rd_data0 = rd_stb && (addr == `UFL_ADDR_DATA) && !dlab;
  wire rd_ls    = rd_stb && (addr == `UFL_ADDR_LINESTAT);
  wire rx_clr_w = wr_fc && wr_data[`UFL_FC_RXCLR];
  wire tx_clr_w = wr_fc && wr_data[`UFL_FC_TXCLR];

  assign dma_mode     = dma_reg;
  assign fifo_enabled = fen_reg;

  always @(posedge clk) begin
    if (srst) begin
      fen_reg   <= 1'b0;
      dma_reg   <= 1'b0;
      txtrg_reg <= 2'h0;
      rxtrg_reg <= 2'h0;
      lc_reg    <= `UFL_LC_RST;
      divlo_reg <= `UFL_DIVLO_RST;
      divhi_reg <= `UFL_DIVHI_RST;
    end else if (wr_stb) begin
      case (addr)
        `UFL_ADDR_DATA: begin
          if (dlab) begin
            divlo_reg <= wr_data;
          end
        end
        `UFL_ADDR_DIVHI: begin
          if (dlab) begin
            divhi_reg <= wr_data;
          end
        end
        `UFL_ADDR_FIFOCTL: begin
          fen_reg   <= wr_data[`UFL_FC_EN];
          dma_reg   <= wr_data[`UFL_FC_DMA];
          rxtrg_reg <= wr_data[`UFL_FC_RXTRG_HI:`UFL_FC_RXTRG_LO];
          if (enhanced_function_enable) begin
            txtrg_reg <= wr_data[`UFL_FC_TXTRG_HI:`UFL_FC_TXTRG_LO];
          end
        end
        `UFL_ADDR_LINECTL: begin
          lc_reg <= wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baud tick: one pulse per sixteenth of a bit
  // ----------------------------------------------------------------
  reg  [15:0] bcnt_reg;
  wire [15:0] div_w   = {divhi_reg, divlo_reg};
  wire        tick    = (bcnt_reg == 16'h0000);

  // A divisor of zero behaves as one, so the line never stalls.
  always @(posedge clk) begin
    if (srst || tick) begin
      bcnt_reg <= (div_w == 16'h0000) ? 16'h0000 : div_w - 16'h0001;
    end else begin
      bcnt_reg <= bcnt_reg - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  wire [10:0] rxf_head;
  wire [AW:0] rxf_cnt;
  wire        rxf_full;
  wire        rxf_empty;
  wire [7:0]  txf_head;
  wire [AW:0] txf_cnt;
  wire        txf_full;
  wire        txf_empty;
  reg         rx_push;
  reg  [10:0] rx_word;
  reg         tx_pop;

  // With FIFOs off, every new character restarts the FIFO at entry zero.
  wire rx_over = !fen_reg && rx_push;

  ufl_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_rxf (
    .clk   (clk),
    .srst  (srst),
    .clr   (rx_clr_w || rx_over),
    .push  (rx_push),
    .pop   (rd_data0),
    .din   (rx_word),
    .head  (rxf_head),
    .count (rxf_cnt),
    .full  (rxf_full),
    .empty (rxf_empty)
  );

  // The transmit FIFO stays in use with FIFOs off; a write when full is dropped.
  ufl_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_txf (
    .clk   (clk),
    .srst  (srst),
    .clr   (tx_clr_w),
    .push  (wr_data0),
    .pop   (tx_pop),
    .din   (wr_data),
    .head  (txf_head),
    .count (txf_cnt),
    .full  (txf_full),
    .empty (txf_empty)
  );

  // ----------------------------------------------------------------
  // Trigger levels
  // ----------------------------------------------------------------
  reg [6:0] txtrg_lvl;
  reg [6:0] rxtrg_lvl;

  always @* begin
    case (txtrg_reg)
      2'h0:    txtrg_lvl = `UFL_TXTRG_0;
      2'h1:    txtrg_lvl = `UFL_TXTRG_1;
      2'h2:    txtrg_lvl = `UFL_TXTRG_2;
      default: txtrg_lvl = `UFL_TXTRG_3;
    endcase
    case (rxtrg_reg)
      2'h0:    rxtrg_lvl = `UFL_RXTRG_0;
      2'h1:    rxtrg_lvl = `UFL_RXTRG_1;
      2'h2:    rxtrg_lvl = `UFL_RXTRG_2;
      default: rxtrg_lvl = `UFL_RXTRG_3;
    endcase
  end

  wire [AW:0] tx_free = DEPTH[AW:0] - txf_cnt;
  assign tx_trigger_hit = (tx_free >= txtrg_lvl);
  assign rx_trigger_hit = (rxf_cnt >= rxtrg_lvl);

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  reg [5:0] rs_reg;
  reg [3:0] rsc_reg;
  reg [2:0] rbit_reg;
  reg [7:0] rsh_reg;
  reg       rpar_reg;
  reg       rbrk_reg;
  wire      rmid = tick && (rsc_reg == `UFL_OVS_LAST);
  wire      rlast = (rbit_reg == {1'b1, lc_reg[1:0]});
  // Shifted bits arrive high-aligned; realign by word length.
  wire [7:0] rx_data_w = wmask(rsh_reg >> (3'h3 - {1'b0, lc_reg[1:0]}),
                               lc_reg[1:0]);

  always @(posedge clk) begin
    if (srst) begin
      rs_reg   <= RS_IDLE;
      rsc_reg  <= 4'h0;
      rbit_reg <= 3'h0;
      rsh_reg  <= 8'h00;
      rpar_reg <= 1'b0;
      rbrk_reg <= 1'b0;
      rx_push  <= 1'b0;
      rx_word  <= 11'h000;
    end else begin
      rx_push <= 1'b0;
      if (tick) begin
        rsc_reg <= rsc_reg + 4'h1;
      end
      case (rs_reg)
        RS_IDLE: begin
          rsc_reg  <= 4'h0;
          rbit_reg <= 3'h0;
          rsh_reg  <= 8'h00;
          if (!rx) begin
            rs_reg <= RS_STRT;
          end
        end
        RS_STRT: begin
          if (tick && rsc_reg == `UFL_MID_START) begin
            rsc_reg <= 4'h0;
            // A start bit gone high by mid bit was noise.
            rs_reg  <= rx ? RS_IDLE : RS_DATA;
          end
        end
        RS_DATA: begin
          if (rmid) begin
            rsh_reg  <= {rx, rsh_reg[7:1]};
            rbit_reg <= rbit_reg + 3'h1;
            if (rlast) begin
              rs_reg <= lc_reg[`UFL_LC_PAREN] ? RS_PAR : RS_STOP;
            end
          end
        end
        RS_PAR: begin
          if (rmid) begin
            rpar_reg <= rx;
            rs_reg   <= RS_STOP;
          end
        end
        RS_STOP: begin
          if (rmid) begin
            rx_push <= 1'b1;
            // Low start, data, parity and stop together mean a break.
            if (!rx && rsh_reg == 8'h00 && !(lc_reg[`UFL_LC_PAREN] && rpar_reg)) begin
              rx_word <= {3'h4, 8'h00};
              rs_reg  <= RS_BRKW;
            end else begin
              rx_word[10]  <= 1'b0;
              rx_word[9]   <= !rx;
              rx_word[8]   <= lc_reg[`UFL_LC_PAREN] &&
                              (rpar_reg != par_bit(rx_data_w, lc_reg));
              rx_word[7:0] <= rx_data_w;
              rs_reg       <= RS_IDLE;
            end
          end
        end
        RS_BRKW: begin
          if (rx) begin
            rs_reg <= RS_IDLE;
          end
        end
        default: rs_reg <= RS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Overrun and error accounting
  // ----------------------------------------------------------------
  reg [AW:0] errcnt_reg;
  wire       in_err  = |rx_word[10:8];
  wire       hd_err  = |rxf_head[10:8] && !rxf_empty;
  wire       acc_psh = rx_push && (!rxf_full || !fen_reg);
  wire       ovr_set = rx_push && (fen_reg ? rxf_full : !rxf_empty);

  always @(posedge clk) begin
    if (srst) begin
      ovr_reg    <= 1'b0;
      errcnt_reg <= {(AW+1){1'b0}};
    end else begin
      // A new overrun in the cycle of the status read is kept.
      if (ovr_set) begin
        ovr_reg <= 1'b1;
      end else if (rd_ls) begin
        ovr_reg <= 1'b0;
      end
      if (rx_clr_w || rx_over) begin
        errcnt_reg <= {{AW{1'b0}}, rx_push && in_err};
      end else begin
        errcnt_reg <= errcnt_reg + {{AW{1'b0}}, acc_psh && in_err}
                                 - {{AW{1'b0}}, rd_data0 && hd_err};
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  reg [4:0] ts_reg;
  reg [4:0] tsc_reg;
  reg [2:0] tbit_reg;
  reg [7:0] tsh_reg;
  reg       tpar_reg;
  reg       tline;
  wire      tend  = tick && (tsc_reg == `UFL_OVS_LAST);
  wire      tlast = (tbit_reg == {1'b1, lc_reg[1:0]});
  reg [4:0] stop_last;

  always @* begin
    if (!lc_reg[`UFL_LC_STOP]) begin
      stop_last = `UFL_STOP1_LAST;
    end else if (lc_reg[1:0] == 2'h0) begin
      stop_last = `UFL_STOP15_LAST;
    end else begin
      stop_last = `UFL_STOP2_LAST;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      ts_reg   <= TS_IDLE;
      tsc_reg  <= 5'h00;
      tbit_reg <= 3'h0;
      tsh_reg  <= 8'h00;
      tpar_reg <= 1'b0;
      tline    <= 1'b1;
      tx_pop   <= 1'b0;
    end else begin
      tx_pop <= 1'b0;
      if (tick) begin
        tsc_reg <= tsc_reg + 5'h01;
      end
      case (ts_reg)
        TS_IDLE: begin
          tline    <= 1'b1;
          tbit_reg <= 3'h0;
          if (!txf_empty && !tx_pop && tick) begin
            tx_pop   <= 1'b1;
            tsh_reg  <= wmask(txf_head, lc_reg[1:0]);
            tpar_reg <= par_bit(wmask(txf_head, lc_reg[1:0]), lc_reg);
            tsc_reg  <= 5'h00;
            tline    <= 1'b0;
            ts_reg   <= TS_STRT;
          end
        end
        TS_STRT: begin
          if (tend) begin
            tsc_reg <= 5'h00;
            tline   <= tsh_reg[0];
            tsh_reg <= tsh_reg >> 1;
            ts_reg  <= TS_DATA;
          end
        end
        TS_DATA: begin
          if (tend) begin
            tsc_reg  <= 5'h00;
            tbit_reg <= tbit_reg + 3'h1;
            if (!tlast) begin
              tline   <= tsh_reg[0];
              tsh_reg <= tsh_reg >> 1;
            end else if (lc_reg[`UFL_LC_PAREN]) begin
              tline  <= tpar_reg;
              ts_reg <= TS_PAR;
            end else begin
              tline  <= 1'b1;
              ts_reg <= TS_STOP;
            end
          end
        end
        TS_PAR: begin
          if (tend) begin
            tsc_reg <= 5'h00;
            tline   <= 1'b1;
            ts_reg  <= TS_STOP;
          end
        end
        TS_STOP: begin
          if (tick && tsc_reg == stop_last) begin
            ts_reg <= TS_IDLE;
          end
        end
        default: ts_reg <= TS_IDLE;
      endcase
    end
  end

  // Break overrides the line but lets the shifter keep running.
  always @(posedge clk) begin
    if (srst) begin
      tx <= 1'b1;
    end else begin
      tx <= tline && !lc_reg[`UFL_LC_BREAK];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] ls_w;
  assign ls_w[`UFL_LS_DATA] = !rxf_empty;
  assign ls_w[`UFL_LS_OVR]  = ovr_reg;
  assign ls_w[`UFL_LS_PAR]  = rxf_head[8] && !rxf_empty;
  assign ls_w[`UFL_LS_FRM]  = rxf_head[9] && !rxf_empty;
  assign ls_w[`UFL_LS_BRK]  = rxf_head[10] && !rxf_empty;
  assign ls_w[`UFL_LS_THE]  = txf_empty;
  assign ls_w[`UFL_LS_TEMT] = txf_empty && ts_reg[0] && !tx_pop;
  assign ls_w[`UFL_LS_ERR]  = (errcnt_reg != {(AW+1){1'b0}});

  // Status is sampled on the strobe edge, before the pop takes effect; the host never sees a half-updated head.
  always @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        `UFL_ADDR_DATA:     rd_data <= dlab ? divlo_reg : rxf_head[7:0];
        `UFL_ADDR_DIVHI:    rd_data <= dlab ? divhi_reg : 8'h00;
        `UFL_ADDR_LINECTL:  rd_data <= lc_reg;
        `UFL_ADDR_LINESTAT: rd_data <= ls_w;
        default:            rd_data <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== logic/ufl_regs.vh
// Register map, field positions, reset values and timing counts of the UART channel.
// Assumes inclusion by bare name from the design files of this block.
`ifndef UFL_REGS_VH
`define UFL_REGS_VH

// Register addresses on the 3-bit host bus.
`define UFL_ADDR_DATA     3'h0
`define UFL_ADDR_DIVHI    3'h1
`define UFL_ADDR_FIFOCTL  3'h2
`define UFL_ADDR_LINECTL  3'h3
`define UFL_ADDR_LINESTAT 3'h5

// fifo_control fields.
`define UFL_FC_EN        0
`define UFL_FC_RXCLR     1
`define UFL_FC_TXCLR     2
`define UFL_FC_DMA       3
`define UFL_FC_TXTRG_LO  4
`define UFL_FC_TXTRG_HI  5
`define UFL_FC_RXTRG_LO  6
`define UFL_FC_RXTRG_HI  7

// line_format_control fields.
`define UFL_LC_WLEN_LO   0
`define UFL_LC_WLEN_HI   1
`define UFL_LC_STOP      2
`define UFL_LC_PAREN     3
`define UFL_LC_EVEN      4
`define UFL_LC_FORCE     5
`define UFL_LC_BREAK     6
`define UFL_LC_DLAB      7

// line_status fields.
`define UFL_LS_DATA      0
`define UFL_LS_OVR       1
`define UFL_LS_PAR       2
`define UFL_LS_FRM       3
`define UFL_LS_BRK       4
`define UFL_LS_THE       5
`define UFL_LS_TEMT      6
`define UFL_LS_ERR       7

// Reset values.
`define UFL_LC_RST       8'h00
`define UFL_DIVLO_RST    8'h01
`define UFL_DIVHI_RST    8'h00

// Oversampling: sixteen ticks per bit, sampled at mid bit.
`define UFL_OVS_LAST     5'h0f
`define UFL_MID_START    4'h7
`define UFL_STOP1_LAST   5'h0f
`define UFL_STOP15_LAST  5'h17
`define UFL_STOP2_LAST   5'h1f

// Trigger levels.
`define UFL_TXTRG_0      7'h08
`define UFL_TXTRG_1      7'h10
`define UFL_TXTRG_2      7'h20
`define UFL_TXTRG_3      7'h38
`define UFL_RXTRG_0      7'h08
`define UFL_RXTRG_1      7'h10
`define UFL_RXTRG_2      7'h38
`define UFL_RXTRG_3      7'h3c

`endif

// ===== logic/ufl_fifo.v
// Flip-flop FIFO with clear, used for both directions of the channel.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module ufl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  // Clock and reset
  input  wire             clk,
  input  wire             srst,
  // Control
  input  wire             clr,
  input  wire             push,
  input  wire             pop,
  input  wire [WIDTH-1:0] din,
  // State
  output wire [WIDTH-1:0] head,
  output wire [AW:0]      count,
  output wire             full,
  output wire             empty
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;

  wire do_push = push && !full;
  wire do_pop  = pop && !empty;

  assign head  = mem_reg[rp_reg];
  assign count = cnt_reg;
  assign full  = (cnt_reg == DEPTH[AW:0]);
  assign empty = (cnt_reg == {(AW+1){1'b0}});

  // A clear with a push in the same cycle leaves just the new word in entry zero.
  always @(posedge clk) begin
    if (srst) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else if (clr) begin
      rp_reg  <= {AW{1'b0}};
      wp_reg  <= push ? {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
      cnt_reg <= push ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
      if (push) begin
        mem_reg[0] <= din;
      end
    end else begin
      if (do_push) begin
        mem_reg[wp_reg] <= din;
        wp_reg          <= wp_reg + 1'b1;
      end
      if (do_pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/ufl_uart_properties.sv
// Concurrent checks on the ports of one UART channel.
// Assumes divisor 1 while traffic runs and host strobes one cycle wide.
`timescale 1ns/100ps
`default_nettype none

module ufl_uart_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Host port
  input wire logic [2:0] addr,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic       enhanced_function_enable,
  // Serial line and status
  input wire logic       rx,
  input wire logic       tx,
  input wire logic       dma_mode,
  input wire logic       fifo_enabled,
  input wire logic       tx_trigger_hit,
  input wire logic       rx_trigger_hit
);
  // ----------------------------------------
  // Shadow registers
  // ----------------------------------------
  logic [7:0] lc_q;
  logic [7:0] div_q;
  logic       tx_q;
  logic [7:0] run_q;

  // The run counter saturates so that long idle spans never wrap.
  always_ff @(posedge clk) begin
    if (srst) begin
      lc_q  <= 8'h00;
      div_q <= 8'h01;
      tx_q  <= 1'b1;
      run_q <= 8'hff;
    end else begin
      if (wr_stb && addr == 3'h3) lc_q <= wr_data;
      if (wr_stb && addr == 3'h0 && lc_q[7]) div_q <= wr_data;
      tx_q  <= tx;
      run_q <= (tx != tx_q) ? 8'h00 : ((run_q == 8'hff) ? run_q : run_q + 8'h01);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  fifo_en_a: assert property (
    wr_stb && addr == 3'h2 |=> fifo_enabled == $past(wr_data[0])) else $error("fifo enable");
  dma_sel_a: assert property (
    wr_stb && addr == 3'h2 |=> dma_mode == $past(wr_data[3])) else $error("dma select");
  fc_wo_a: assert property (
    rd_stb && addr == 3'h2 |=> rd_data == 8'h00) else $error("fifo control readable");
  lc_rb_a: assert property (
    rd_stb && addr == 3'h3 |=> rd_data == lc_q) else $error("line format readback");
  div_rb_a: assert property (
    rd_stb && addr == 3'h0 && lc_q[7] |=> rd_data == div_q) else $error("divisor readback");
  brk_low_a: assert property (
    lc_q[6] [*3] |-> !tx) else $error("break not low");
  temt_a: assert property (
    rd_stb && addr == 3'h5 |=> !rd_data[6] || rd_data[5]) else $error("empty flags");
  err_any_a: assert property (
    rd_stb && addr == 3'h5 |=> rd_data[0] || (!rd_data[7] && rd_data[4:2] == 3'h0))
    else $error("error flags without data");
  tx_runs_a: assert property (
    tx != tx_q |-> run_q >= 8'd15) else $error("serial bit too short");
  rst_vals_a: assert property (disable iff (1'b0)
    srst |=> tx && !fifo_enabled && !dma_mode && !rx_trigger_hit) else $error("reset values");

  cv_brk: cover property (rd_stb && addr == 3'h5 ##1 rd_data[4]);
  cv_ovr: cover property (rd_stb && addr == 3'h5 ##1 rd_data[1]);
  cv_trg: cover property ($rose(rx_trigger_hit));
endmodule

bind ufl_uart ufl_uart_properties chk_i (
  .clk(clk), .srst(srst), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .wr_data(wr_data), .rd_data(rd_data), .enhanced_function_enable(enhanced_function_enable),
  .rx(rx), .tx(tx), .dma_mode(dma_mode), .fifo_enabled(fifo_enabled),
  .tx_trigger_hit(tx_trigger_hit), .rx_trigger_hit(rx_trigger_hit));

`default_nettype wire

// ===== tb/ufl_peer.sv
// Remote serial peer: sends characters to rx and captures them from tx.
// Assumes divisor 1, so one bit lasts sixteen clocks.
`timescale 1ns/100ps
`default_nettype none

module ufl_peer (
  // Clock and serial lines
  input  wire logic clk,
  output var logic  rx_line,
  input  wire logic tx_line
);
  initial rx_line = 1'b1;

  // Start low, data LSB first, parity p if pe, stop level s, then idle high.
  task automatic send(input logic [7:0] d, input int n, input int pe, input logic p,
                      input logic s);
    int i;
    rx_line <= 1'b0;
    repeat (16) @(posedge clk);
    for (i = 0; i < n + pe; i++) begin
      rx_line <= (i < n) ? d[i] : p;
      repeat (16) @(posedge clk);
    end
    rx_line <= s;
    repeat (16) @(posedge clk);
    rx_line <= 1'b1;
    repeat (16) @(posedge clk);
  endtask

  // Samples each bit mid way; the stop level lands just above the parity bit.
  task automatic grab(input int n, input int pe, output logic [9:0] v);
    int i;
    v = 10'h000;
    while (tx_line !== 1'b0) @(posedge clk);
    repeat (8) @(posedge clk);
    for (i = 0; i <= n + pe; i++) begin
      repeat (16) @(posedge clk);
      v[i] = tx_line;
    end
  endtask
endmodule

`default_nettype wire

// ===== tb/uart_fifo_line_control_bench.sv
// Self-checking bench for one UART channel against a serial peer.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/100ps
`default_nettype none

module uart_fifo_line_control_bench;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic       enhanced_function_enable = 1'b0;
  wire  [7:0] rd_data;
  wire        rx;
  wire        tx;
  wire        dma_mode;
  wire        fifo_enabled;
  wire        tx_trigger_hit;
  wire        rx_trigger_hit;
  int         err_count = 0;
  int         compares = 0;

  always #20 clk = ~clk;

  ufl_uart uut (.clk(clk), .srst(srst), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wr_data(wr_data), .rd_data(rd_data), .enhanced_function_enable(enhanced_function_enable),
    .rx(rx), .tx(tx), .dma_mode(dma_mode), .fifo_enabled(fifo_enabled),
    .tx_trigger_hit(tx_trigger_hit), .rx_trigger_hit(rx_trigger_hit));
  ufl_peer peer (.clk(clk), .rx_line(rx), .tx_line(tx));

  // ----------------------------------------
  // Host access and comparison
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    d = rd_data;
  endtask

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] v;
    wr(3'h3, 8'h1b);
    rd(3'h3, v);
    chk("line_fmt", 8'h1b, v);
    wr(3'h2, 8'h09);
    rd(3'h2, v);
    chk("fifo_ctl", 8'h00, v);
    chk("fifo_on", 1'b1, fifo_enabled);
    chk("dma_mode", 1'b1, dma_mode);
    wr(3'h3, 8'h80);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h01);
    rd(3'h0, v);
    chk("div_lo", 8'h01, v);
    wr(3'h3, 8'h03);
    rd(3'h5, v);
    chk("status", 8'h60, v);
    $display("t_regs done");
  endtask

  task automatic t_tx();
    logic [9:0] v;
    wr(3'h3, 8'h1b);
    wr(3'h0, 8'ha5);
    peer.grab(8, 1, v);
    chk("tx_even", 10'h2a5, v);
    repeat (40) @(posedge clk);
    wr(3'h3, 8'h2c);
    wr(3'h0, 8'h13);
    peer.grab(5, 1, v);
    chk("tx_forced", 10'h073, v);
    repeat (60) @(posedge clk);
    wr(3'h3, 8'h43);
    repeat (20) @(posedge clk);
    chk("tx_break", 1'b0, tx);
    wr(3'h3, 8'h03);
    repeat (20) @(posedge clk);
    $display("t_tx done");
  endtask

  task automatic t_trig();
    logic [7:0] v;
    int i;
    wr(3'h2, 8'h31);
    for (i = 0; i < 10; i++) wr(3'h0, i[7:0]);
    chk("tx_trig_lo", 1'b1, tx_trigger_hit);
    enhanced_function_enable <= 1'b1;
    wr(3'h2, 8'h31);
    chk("tx_trig_56", 1'b0, tx_trigger_hit);
    enhanced_function_enable <= 1'b0;
    wr(3'h2, 8'h35);
    rd(3'h5, v);
    chk("tx_cleared", 1'b1, v[5]);
    repeat (400) @(posedge clk);
    rd(3'h5, v);
    chk("tx_idle", 8'h60, v);
    $display("t_trig done");
  endtask

  task automatic t_rx();
    logic [7:0] v;
    int i;
    wr(3'h2, 8'h01);
    for (i = 0; i < 8; i++) begin
      if (i == 7) chk("rx_trig_7", 1'b0, rx_trigger_hit);
      peer.send(8'h30 + i[7:0], 8, 0, 1'b0, 1'b1);
    end
    chk("rx_trig_8", 1'b1, rx_trigger_hit);
    rd(3'h5, v);
    rd(3'h5, v);
    chk("status", 8'h61, v);
    for (i = 0; i < 8; i++) begin
      rd(3'h0, v);
      chk("rx_data", 8'h30 + i[7:0], v);
    end
    rd(3'h5, v);
    chk("status", 8'h60, v);
    $display("t_rx done");
  endtask

  task automatic t_err();
    logic [7:0] v;
    wr(3'h3, 8'h1b);
    peer.send(8'h01, 8, 1, 1'b0, 1'b1);
    peer.send(8'h00, 8, 1, 1'b0, 1'b0);
    peer.send(8'h55, 8, 1, 1'b0, 1'b0);
    peer.send(8'h0f, 8, 1, 1'b0, 1'b1);
    rd(3'h5, v);
    chk("parity", 8'he5, v);
    rd(3'h0, v);
    rd(3'h5, v);
    chk("break", 2'h3, {v[7], v[4]});
    rd(3'h0, v);
    chk("break_data", 8'h00, v);
    rd(3'h5, v);
    chk("framing", 8'he9, v);
    rd(3'h0, v);
    rd(3'h5, v);
    chk("clean", 8'h61, v);
    rd(3'h0, v);
    chk("clean_data", 8'h0f, v);
    $display("t_err done");
  endtask

  task automatic t_ovr();
    logic [7:0] v;
    wr(3'h3, 8'h03);
    wr(3'h2, 8'h00);
    peer.send(8'h11, 8, 0, 1'b0, 1'b1);
    peer.send(8'h22, 8, 0, 1'b0, 1'b1);
    rd(3'h5, v);
    chk("overrun", 8'h63, v);
    rd(3'h0, v);
    chk("overwrite", 8'h22, v);
    wr(3'h2, 8'h01);
    peer.send(8'h44, 8, 0, 1'b0, 1'b1);
    wr(3'h2, 8'h03);
    rd(3'h5, v);
    chk("rx_cleared", 8'h60, v);
    $display("t_ovr done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_tx();
    t_trig();
    t_rx();
    t_err();
    t_ovr();
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule

`default_nettype wire
